// >>> nqc_params.svh
// Constants for the network ingress QoS classifier
`ifndef NQC_PARAMS_SVH
`define NQC_PARAMS_SVH
`define NQC_DSCP_ENTRIES 64
`define NQC_PRIO_ENTRIES 8
`define NQC_EXP_ENTRIES 8
`define NQC_TCI_PRIO_MSB 15
`define NQC_TCI_PRIO_LSB 13
`define NQC_TCI_DE_BIT 12
`define NQC_FB_CLASS_RST 3'h0
`define NQC_FB_PROF_RST 1'h1
`define NQC_DSCP_EF 6'h2e
`define NQC_DSCP_NC1 6'h30
`define NQC_DSCP_NC2 6'h38
`define NQC_DSCP_AF33 6'h1e
`define NQC_CS_SHIFT 3
`define NQC_ERR_NONE 2'h0
`define NQC_ERR_CLASS 2'h1
`define NQC_ERR_PROFILE 2'h2
`define NQC_ERR_ALIAS 2'h3
`endif

// >>> nqc_pkg.sv
// Types for the network ingress QoS classifier
package nqc_pkg;
  // Eight forwarding classes, lowest priority first
  typedef enum logic [2:0] {
    NQC_LOWEST_PRIORITY_CLASS = 3'h0,
    NQC_L2_CLASS = 3'h1,
    NQC_ASSURED_CLASS = 3'h2,
    NQC_L1_CLASS = 3'h3,
    NQC_HIGH_TWO_CLASS = 3'h4,
    NQC_EXPEDITED_CLASS = 3'h5,
    NQC_HIGH_ONE_CLASS = 3'h6,
    NQC_NETWORK_CONTROL_CLASS = 3'h7
  } nqc_class_type;

  // Profile choice for tag priority rules
  typedef enum logic [1:0] {
    NQC_PROF_IN,
    NQC_PROF_OUT,
    NQC_PROF_DERIVE_PROFILE_FROM_DROP_ELIGIBLE
  } nqc_prof_sel_type;

  // Header fields handed over by the parser
  typedef struct packed {
    logic valid;
    logic is_ip;
    logic is_labelled;
    logic has_tag;
    logic [5:0] dscp;
    logic [2:0] exp;
    logic [15:0] tci;
    logic [2:0] enq_prio;
  } nqc_hdr_type;

  // Classification result; profile 1 means out-of-profile
  typedef struct packed {
    logic valid;
    logic [2:0] fclass;
    logic out_profile;
    logic [2:0] enq_prio;
  } nqc_result_type;

  // Configuration write command
  typedef struct packed {
    logic valid;
    logic delete;
    logic [1:0] table_sel;
    logic [5:0] key;
    logic class_defined;
    logic [3:0] fclass;
    logic prio_defined;
    logic [2:0] enq_prio;
    logic [1:0] prof_sel;
  } nqc_cfg_type;

  // Table selector codes
  typedef enum logic [1:0] {
    NQC_TBL_FALLBACK,
    NQC_TBL_DSCP,
    NQC_TBL_EXP,
    NQC_TBL_TAG
  } nqc_table_type;
endpackage

// >>> nqc_classifier.sv
// Network ingress QoS classifier: tables, checks and per-packet lookup
//
// What this block does
// - Hold a class and profile for each of 64 DSCP values; unmapped uses fallback.
// - Reset sets the fallback to lowest priority class, out-of-profile.
// - Each fallback write fully replaces the stored class and profile.
// - Tag priority comes from the top three bits of the tag control field.
// - The tag rule table has eight entries, keyed by priority 0 to 7.
// - A tag rule with a class replaces it; without one the class is kept.
// - A tag rule without enqueuing priority keeps the earlier priority.
// - Rewriting a tag rule replaces all fields; missing ones become inherit.
// - Each tag rule picks in, out or derive from drop eligible.
// - In derive mode, drop eligible clear means in, set means out.
// - Deleting a tag rule takes effect at once for all following packets.
// - Deleting a DSCP entry makes that value use the fallback.
// - Expedited is 46, network control 48 and 56, af33 is 30.
// - Class selector n resolves to eight times n.
// - DSCP table keyed by value; mapping an already mapped value is refused.
// - Expedited, high one and network control DSCP entries take only in-profile.
// - Lowest priority class DSCP entries take only out-of-profile.
// - The output profile flag lets queuing favour in-profile under congestion.
// - A programmed class must be one of eight; other codes are refused.
// - Labelled packets use the EXP table, unlabelled IP packets the DSCP table.
// - The EXP key is three bits, eight mappable values.
`timescale 1ns/1ps
`default_nettype none
`include "nqc_params.svh"

module nqc_classifier
  import nqc_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire nqc_hdr_type i_hdr,
  input wire nqc_cfg_type i_cfg,
  output nqc_result_type o_result,
  output logic o_cfg_ack,
  output logic [1:0] o_cfg_err
);

  // Per-entry storage; valid bits say whether a DSCP or EXP value is mapped
  logic [`NQC_DSCP_ENTRIES-1:0] dscp_vld_r;
  logic [2:0] dscp_cls_r [`NQC_DSCP_ENTRIES];
  logic dscp_out_r [`NQC_DSCP_ENTRIES];
  logic [`NQC_EXP_ENTRIES-1:0] exp_vld_r;
  logic [2:0] exp_cls_r [`NQC_EXP_ENTRIES];
  logic exp_out_r [`NQC_EXP_ENTRIES];
  logic [`NQC_PRIO_ENTRIES-1:0] tag_vld_r;
  logic [`NQC_PRIO_ENTRIES-1:0] tag_cls_def_r;
  logic [`NQC_PRIO_ENTRIES-1:0] tag_pri_def_r;
  logic [2:0] tag_cls_r [`NQC_PRIO_ENTRIES];
  logic [2:0] tag_pri_r [`NQC_PRIO_ENTRIES];
  nqc_prof_sel_type tag_prof_r [`NQC_PRIO_ENTRIES];
  logic [2:0] fb_cls_r;
  logic fb_out_r;

  // Resolve a class selector number to its code point
  function automatic logic [5:0] cs_to_dscp(input logic [2:0] sel);
    cs_to_dscp = {sel, 3'h0};
  endfunction

  // Strict class-to-profile pairing for DSCP entries
  function automatic logic prof_allowed(input logic [2:0] cls, input logic out_p);
    logic ok;
    ok = 1'b1;
    if ((cls == NQC_EXPEDITED_CLASS) || (cls == NQC_HIGH_ONE_CLASS) ||
        (cls == NQC_NETWORK_CONTROL_CLASS)) begin
      ok = !out_p;
    end else if (cls == NQC_LOWEST_PRIORITY_CLASS) begin
      ok = out_p;
    end
    prof_allowed = ok;
  endfunction

  // Decode of the configuration command
  logic cfg_out_p;
  logic cls_bad;
  logic prof_bad;
  logic alias_bad;
  logic tag_prof_bad;
  logic [1:0] err_nxt;
  assign cfg_out_p = (i_cfg.prof_sel == NQC_PROF_OUT);
  assign cls_bad = i_cfg.fclass[3];
  assign tag_prof_bad = (i_cfg.prof_sel > NQC_PROF_DERIVE_PROFILE_FROM_DROP_ELIGIBLE);
  assign prof_bad = (i_cfg.table_sel == NQC_TBL_DSCP) &&
                    (!prof_allowed(i_cfg.fclass[2:0], cfg_out_p) || i_cfg.prof_sel[1]);
  assign alias_bad = (i_cfg.table_sel == NQC_TBL_DSCP) && dscp_vld_r[i_cfg.key];

  // Error code; deletes never fail
  always_comb begin
    err_nxt = `NQC_ERR_NONE;
    if (i_cfg.valid && !i_cfg.delete) begin
      if (cls_bad && (i_cfg.class_defined || (i_cfg.table_sel != NQC_TBL_TAG))) begin
        err_nxt = `NQC_ERR_CLASS;
      end else if (prof_bad || ((i_cfg.table_sel == NQC_TBL_TAG) && tag_prof_bad)) begin
        err_nxt = `NQC_ERR_PROFILE;
      end else if (alias_bad) begin
        err_nxt = `NQC_ERR_ALIAS;
      end
    end
  end

  logic cfg_wr;
  assign cfg_wr = i_cfg.valid && !i_cfg.delete && (err_nxt == `NQC_ERR_NONE);

  // Fallback entry: a single slot, overwritten whole
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      fb_cls_r <= `NQC_FB_CLASS_RST;
      fb_out_r <= `NQC_FB_PROF_RST;
    end else if (cfg_wr && (i_cfg.table_sel == NQC_TBL_FALLBACK)) begin
      fb_cls_r <= i_cfg.fclass[2:0];
      fb_out_r <= cfg_out_p;
    end
  end

  // DSCP table, indexed by numeric value, not by name
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      dscp_vld_r <= '0;
    end else if (i_cfg.valid && (i_cfg.table_sel == NQC_TBL_DSCP)) begin
      if (i_cfg.delete) begin
        dscp_vld_r[i_cfg.key] <= 1'b0;
      end else if (cfg_wr) begin
        dscp_vld_r[i_cfg.key] <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (cfg_wr && (i_cfg.table_sel == NQC_TBL_DSCP)) begin
      dscp_cls_r[i_cfg.key] <= i_cfg.fclass[2:0];
      dscp_out_r[i_cfg.key] <= cfg_out_p;
    end
  end

  // EXP table, three-bit key
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      exp_vld_r <= '0;
    end else if (i_cfg.valid && (i_cfg.table_sel == NQC_TBL_EXP)) begin
      if (i_cfg.delete) begin
        exp_vld_r[i_cfg.key[2:0]] <= 1'b0;
      end else if (cfg_wr) begin
        exp_vld_r[i_cfg.key[2:0]] <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (cfg_wr && (i_cfg.table_sel == NQC_TBL_EXP)) begin
      exp_cls_r[i_cfg.key[2:0]] <= i_cfg.fclass[2:0];
      exp_out_r[i_cfg.key[2:0]] <= cfg_out_p;
    end
  end

  // Tag priority rules: rewrite replaces every field, absent ones become inherit
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      tag_vld_r <= '0;
      tag_cls_def_r <= '0;
      tag_pri_def_r <= '0;
    end else if (i_cfg.valid && (i_cfg.table_sel == NQC_TBL_TAG)) begin
      if (i_cfg.delete) begin
        tag_vld_r[i_cfg.key[2:0]] <= 1'b0;
      end else if (cfg_wr) begin
        tag_vld_r[i_cfg.key[2:0]] <= 1'b1;
        tag_cls_def_r[i_cfg.key[2:0]] <= i_cfg.class_defined;
        tag_pri_def_r[i_cfg.key[2:0]] <= i_cfg.prio_defined;
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (cfg_wr && (i_cfg.table_sel == NQC_TBL_TAG)) begin
      tag_cls_r[i_cfg.key[2:0]] <= i_cfg.fclass[2:0];
      tag_pri_r[i_cfg.key[2:0]] <= i_cfg.enq_prio;
      tag_prof_r[i_cfg.key[2:0]] <= nqc_prof_sel_type'(i_cfg.prof_sel);
    end
  end

  // Configuration answer, one cycle after the command
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_cfg_ack <= 1'b0;
      o_cfg_err <= `NQC_ERR_NONE;
    end else begin
      o_cfg_ack <= i_cfg.valid;
      o_cfg_err <= i_cfg.valid ? err_nxt : `NQC_ERR_NONE;
    end
  end

  // Per-packet lookup; all stages resolve in one combinational pass
  logic [2:0] prio_key;
  logic de_bit;
  logic [2:0] cls_s1;
  logic out_s1;
  logic [2:0] cls_fin;
  logic out_fin;
  logic [2:0] pri_fin;
  assign prio_key = i_hdr.tci[`NQC_TCI_PRIO_MSB:`NQC_TCI_PRIO_LSB];
  assign de_bit = i_hdr.tci[`NQC_TCI_DE_BIT];

  always_comb begin
    cls_s1 = fb_cls_r;
    out_s1 = fb_out_r;
    if (i_hdr.is_labelled) begin
      if (exp_vld_r[i_hdr.exp]) begin
        cls_s1 = exp_cls_r[i_hdr.exp];
        out_s1 = exp_out_r[i_hdr.exp];
      end
    end else if (i_hdr.is_ip && dscp_vld_r[i_hdr.dscp]) begin
      cls_s1 = dscp_cls_r[i_hdr.dscp];
      out_s1 = dscp_out_r[i_hdr.dscp];
    end
  end

  // Tag override last; unlisted fields inherit the earlier stage
  always_comb begin
    cls_fin = cls_s1;
    out_fin = out_s1;
    pri_fin = i_hdr.enq_prio;
    if (i_hdr.has_tag && tag_vld_r[prio_key]) begin
      if (tag_cls_def_r[prio_key]) begin
        cls_fin = tag_cls_r[prio_key];
      end
      if (tag_pri_def_r[prio_key]) begin
        pri_fin = tag_pri_r[prio_key];
      end
      case (tag_prof_r[prio_key])
        NQC_PROF_IN: out_fin = 1'b0;
        NQC_PROF_OUT: out_fin = 1'b1;
        NQC_PROF_DERIVE_PROFILE_FROM_DROP_ELIGIBLE: out_fin = de_bit;
        default: out_fin = out_s1;
      endcase
    end
  end

  // Registered result; out_profile tells queuing which packets to drop first
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_result <= '0;
    end else begin
      o_result.valid <= i_hdr.valid;
      o_result.fclass <= cls_fin;
      o_result.out_profile <= out_fin;
      o_result.enq_prio <= pri_fin;
    end
  end

  // Assertions
  logic [5:0] cs5_code;
  assign cs5_code = cs_to_dscp(3'h5);

  property p_fallback_reset;
    @(posedge i_core_clk) $past(i_rst) |-> (fb_cls_r == `NQC_FB_CLASS_RST) && fb_out_r;
  endproperty
  a_fallback_reset: assert property (p_fallback_reset) else $error("fallback not reset");

  property p_fallback_replace;
    @(posedge i_core_clk) disable iff (i_rst)
      cfg_wr && (i_cfg.table_sel == NQC_TBL_FALLBACK) |=> (fb_cls_r == $past(i_cfg.fclass[2:0])) &&
      (fb_out_r == $past(cfg_out_p));
  endproperty
  a_fallback_replace: assert property (p_fallback_replace) else $error("fallback not replaced");

  property p_alias_refused;
    @(posedge i_core_clk) disable iff (i_rst)
      i_cfg.valid && !i_cfg.delete && (i_cfg.table_sel == NQC_TBL_DSCP) && dscp_vld_r[i_cfg.key] &&
      !cls_bad && !prof_bad |=> o_cfg_ack && (o_cfg_err == `NQC_ERR_ALIAS);
  endproperty
  a_alias_refused: assert property (p_alias_refused) else $error("alias accepted");

  property p_dscp_delete;
    @(posedge i_core_clk) disable iff (i_rst)
      i_cfg.valid && i_cfg.delete && (i_cfg.table_sel == NQC_TBL_DSCP) |=> !dscp_vld_r[$past(i_cfg.key)];
  endproperty
  a_dscp_delete: assert property (p_dscp_delete) else $error("dscp entry kept");

  property p_strict_high;
    @(posedge i_core_clk) disable iff (i_rst)
      i_cfg.valid && !i_cfg.delete && (i_cfg.table_sel == NQC_TBL_DSCP) && !cls_bad &&
      (i_cfg.fclass[2:0] inside {NQC_EXPEDITED_CLASS, NQC_HIGH_ONE_CLASS, NQC_NETWORK_CONTROL_CLASS}) &&
      cfg_out_p |=> o_cfg_err == `NQC_ERR_PROFILE;
  endproperty
  a_strict_high: assert property (p_strict_high) else $error("out profile accepted");

  property p_strict_low;
    @(posedge i_core_clk) disable iff (i_rst)
      i_cfg.valid && !i_cfg.delete && (i_cfg.table_sel == NQC_TBL_DSCP) && !cls_bad &&
      (i_cfg.fclass[2:0] == NQC_LOWEST_PRIORITY_CLASS) && !cfg_out_p |=> o_cfg_err == `NQC_ERR_PROFILE;
  endproperty
  a_strict_low: assert property (p_strict_low) else $error("in profile accepted");

  property p_bad_class;
    @(posedge i_core_clk) disable iff (i_rst)
      i_cfg.valid && !i_cfg.delete && (i_cfg.table_sel == NQC_TBL_DSCP) && cls_bad |=>
      (o_cfg_err == `NQC_ERR_CLASS) && (dscp_vld_r == $past(dscp_vld_r));
  endproperty
  a_bad_class: assert property (p_bad_class) else $error("bad class accepted");

  property p_derive_de;
    @(posedge i_core_clk) disable iff (i_rst)
      i_hdr.has_tag && tag_vld_r[prio_key] &&
      (tag_prof_r[prio_key] == NQC_PROF_DERIVE_PROFILE_FROM_DROP_ELIGIBLE) |=> o_result.out_profile == $past(de_bit);
  endproperty
  a_derive_de: assert property (p_derive_de) else $error("profile not from drop eligible");

  property p_inherit_class;
    @(posedge i_core_clk) disable iff (i_rst)
      i_hdr.valid && (!i_hdr.has_tag || !tag_vld_r[prio_key] || !tag_cls_def_r[prio_key]) |=>
      o_result.fclass == $past(cls_s1);
  endproperty
  a_inherit_class: assert property (p_inherit_class) else $error("class not inherited");

  property p_inherit_prio;
    @(posedge i_core_clk) disable iff (i_rst)
      i_hdr.valid && (!i_hdr.has_tag || !tag_vld_r[prio_key] || !tag_pri_def_r[prio_key]) |=>
      o_result.enq_prio == $past(i_hdr.enq_prio);
  endproperty
  a_inherit_prio: assert property (p_inherit_prio) else $error("priority not inherited");

  property p_fixed_codes;
    @(posedge i_core_clk) (`NQC_DSCP_EF == 6'h2e) && (`NQC_DSCP_NC1 == cs_to_dscp(3'h6)) &&
      (`NQC_DSCP_NC2 == cs_to_dscp(3'h7)) && (`NQC_DSCP_AF33 == 6'h1e) && (cs5_code == 6'h28);
  endproperty
  a_fixed_codes: assert property (p_fixed_codes) else $error("code point names wrong");

endmodule

`default_nettype wire

// >>> nqc_parser_model.sv
// Model of the upstream parser that offers header fields to the classifier
`timescale 1ns/1ps
`default_nettype none

module nqc_parser_model
  import nqc_pkg::*;
(
  output var nqc_hdr_type o_hdr
);
  nqc_hdr_type last_hdr;

  // Nothing offered until the first packet
  initial begin
    o_hdr = '0;
    last_hdr = '0;
  end

  // Offer one header; tag priority sits in tci[15:13], drop eligible in tci[12]
  task automatic drive(input nqc_hdr_type h);
    last_hdr = h;
    o_hdr = h;
  endtask

  // Withdraw: stale fields are inverted so nobody can lean on them, valid drops with them
  task automatic idle();
    o_hdr = ~last_hdr;
  endtask
endmodule

`default_nettype wire

// >>> nqc_classifier_test.sv
// Self-checking testbench for the network ingress QoS classifier
`timescale 1ns/1ps
`default_nettype none
`include "nqc_params.svh"

module nqc_classifier_test
  import nqc_pkg::*;
;
  logic i_core_clk;
  logic i_rst;
  nqc_hdr_type hdr;
  nqc_cfg_type i_cfg;
  nqc_result_type o_result;
  logic o_cfg_ack;
  logic [1:0] o_cfg_err;
  int err_count;
  int comparisons;
  // Refused DSCP writes: class, profile choice, expected error
  logic [3:0] bad_fc [6] = '{4'h5, 4'h6, 4'h7, 4'h0, 4'h2, 4'h8};
  logic [1:0] bad_ps [6] = '{2'h1, 2'h1, 2'h1, 2'h0, 2'h2, 2'h0};
  logic [1:0] bad_err [6] = '{2'h2, 2'h2, 2'h2, 2'h2, 2'h2, 2'h1};
  logic [2:0] k;

  nqc_classifier i_dut (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_hdr(hdr),
    .i_cfg(i_cfg),
    .o_result(o_result),
    .o_cfg_ack(o_cfg_ack),
    .o_cfg_err(o_cfg_err)
  );

  nqc_parser_model i_par (
    .o_hdr(hdr)
  );

  // 200 MHz clock
  always #2.5 i_core_clk = ~i_core_clk;

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // One config command; the answer stands one cycle, then a quiet cycle so valid is not re-raised at once
  task automatic cfg(input logic del, input logic [1:0] tbl, input logic [5:0] key, input logic cdef,
                     input logic [3:0] fc, input logic pdef, input logic [2:0] ep, input logic [1:0] ps,
                     input logic [1:0] eerr);
    i_cfg = '{1'b1, del, tbl, key, cdef, fc, pdef, ep, ps};
    @(posedge i_core_clk);
    #1;
    chk({5'h00, o_cfg_ack, o_cfg_err}, {5'h00, 1'b1, eerr}, "config answer");
    i_cfg = '0;
    @(posedge i_core_clk);
    #1;
    chk({7'h00, o_cfg_ack}, 8'h00, "config answer drop");
  endtask

  task automatic map(input logic [1:0] tbl, input logic [5:0] key, input logic [3:0] fc,
                     input logic [1:0] ps, input logic [1:0] eerr);
    cfg(1'b0, tbl, key, 1'b1, fc, 1'b0, 3'h0, ps, eerr);
  endtask

  task automatic del(input logic [1:0] tbl, input logic [5:0] key);
    cfg(1'b1, tbl, key, 1'b0, 4'h0, 1'b0, 3'h0, 2'h0, `NQC_ERR_NONE);
  endtask

  task automatic tag(input logic [2:0] p, input logic cdef, input logic [3:0] fc, input logic pdef,
                     input logic [2:0] ep, input logic [1:0] ps, input logic [1:0] eerr);
    cfg(1'b0, NQC_TBL_TAG, {3'h0, p}, cdef, fc, pdef, ep, ps, eerr);
  endtask

  // One packet through the parser model; the result stands one cycle after it is taken
  task automatic pkt(input logic lab, input logic ip, input logic tg, input logic [5:0] dscp,
                     input logic [2:0] exp, input logic [15:0] tci, input logic [2:0] ec,
                     input logic eo, input logic [2:0] eep);
    i_par.drive(nqc_hdr_type'{1'b1, ip, lab, tg, dscp, exp, tci, 3'h2});
    @(posedge i_core_clk);
    #1;
    chk(o_result, {1'b1, ec, eo, eep}, "packet result");
    i_par.idle();
    @(posedge i_core_clk);
    #1;
    chk({7'h00, o_result.valid}, 8'h00, "result valid drop");
  endtask

  task automatic ippk(input logic [5:0] dscp, input logic [2:0] ec, input logic eo);
    pkt(1'b0, 1'b1, 1'b0, dscp, 3'h0, 16'h0000, ec, eo, 3'h2);
  endtask

  task automatic test_done();
    $display("Counts: %0d comparisons, %0d mismatches", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Watchdog: the tests need under two hundred cycles, this allows far more
  initial begin
    #20000;
    err_count++;
    $display("BAD %0t watchdog expired", $time);
    test_done();
  end

  initial begin
    i_core_clk = 1'b0;
    i_rst = 1'b1;
    i_cfg = '0;
    err_count = 0;
    comparisons = 0;
    repeat (16) @(posedge i_core_clk);
    #1;
    chk(o_result, 8'h00, "result in reset");
    chk({5'h00, o_cfg_ack, o_cfg_err}, 8'h00, "config in reset");
    i_rst = 1'b0;
    // Empty tables fall back to the reset fallback entry
    ippk(`NQC_DSCP_EF, 3'h0, 1'b1);
    pkt(1'b0, 1'b0, 1'b0, 6'h00, 3'h0, 16'h0000, 3'h0, 1'b1, 3'h2);
    $display("test reset done");
    // Each fallback write replaces both fields; a bad class changes nothing
    map(NQC_TBL_FALLBACK, 6'h00, 4'h3, 2'h0, `NQC_ERR_NONE);
    ippk(6'h05, 3'h3, 1'b0);
    map(NQC_TBL_FALLBACK, 6'h00, 4'h6, 2'h1, `NQC_ERR_NONE);
    ippk(6'h05, 3'h6, 1'b1);
    map(NQC_TBL_FALLBACK, 6'h00, 4'h8, 2'h0, `NQC_ERR_CLASS);
    ippk(6'h05, 3'h6, 1'b1);
    $display("test fallback done");
    // Map, alias refusal, delete
    map(NQC_TBL_DSCP, `NQC_DSCP_EF, 4'h5, 2'h0, `NQC_ERR_NONE);
    ippk(6'h2e, 3'h5, 1'b0);
    map(NQC_TBL_DSCP, `NQC_DSCP_EF, 4'h2, 2'h0, `NQC_ERR_ALIAS);
    ippk(6'h2e, 3'h5, 1'b0);
    del(NQC_TBL_DSCP, `NQC_DSCP_EF);
    ippk(6'h2e, 3'h6, 1'b1);
    // Profile limits per class and illegal codes; refused writes leave the value unmapped
    for (int i = 0; i < 6; i++) begin
      map(NQC_TBL_DSCP, 6'h30, bad_fc[i], bad_ps[i], bad_err[i]);
      ippk(6'h30, 3'h6, 1'b1);
    end
    map(NQC_TBL_DSCP, 6'h01, 4'h0, 2'h1, `NQC_ERR_NONE);
    ippk(6'h01, 3'h0, 1'b1);
    // Class selectors n map at eight times n
    for (int n = 1; n < 8; n++) begin
      k = 3'(n);
      map(NQC_TBL_DSCP, 6'(8 * n), {1'b0, k}, 2'h0, `NQC_ERR_NONE);
      ippk(6'(8 * n), k, 1'b0);
    end
    map(NQC_TBL_DSCP, 6'h1e, 4'h2, 2'h1, `NQC_ERR_NONE);
    ippk(`NQC_DSCP_AF33, 3'h2, 1'b1);
    $display("test dscp done");
    // Labelled packets use the three-bit EXP key, a miss goes to fallback not DSCP
    for (int e = 0; e < 8; e++) begin
      k = 3'(e);
      map(NQC_TBL_EXP, {3'h0, k}, {1'b0, k}, {1'b0, k[0]}, `NQC_ERR_NONE);
      pkt(1'b1, 1'b1, 1'b0, 6'h08, k, 16'h0000, k, k[0], 3'h2);
    end
    del(NQC_TBL_EXP, 6'h00);
    pkt(1'b1, 1'b1, 1'b0, 6'h08, 3'h0, 16'h0000, 3'h6, 1'b1, 3'h2);
    $display("test exp done");
    // Tag rules: override, inherit, profile modes, boundaries and delete
    tag(3'h5, 1'b1, 4'h7, 1'b1, 3'h6, 2'h0, `NQC_ERR_NONE);
    pkt(1'b0, 1'b1, 1'b1, 6'h08, 3'h0, 16'ha000, 3'h7, 1'b0, 3'h6);
    pkt(1'b0, 1'b1, 1'b0, 6'h08, 3'h0, 16'ha000, 3'h1, 1'b0, 3'h2);
    pkt(1'b0, 1'b1, 1'b1, 6'h08, 3'h0, 16'h8000, 3'h1, 1'b0, 3'h2);
    tag(3'h5, 1'b0, 4'h0, 1'b0, 3'h0, 2'h2, `NQC_ERR_NONE);
    pkt(1'b0, 1'b1, 1'b1, 6'h08, 3'h0, 16'ha000, 3'h1, 1'b0, 3'h2);
    pkt(1'b0, 1'b1, 1'b1, 6'h08, 3'h0, 16'hb000, 3'h1, 1'b1, 3'h2);
    tag(3'h5, 1'b0, 4'h0, 1'b0, 3'h0, 2'h1, `NQC_ERR_NONE);
    pkt(1'b0, 1'b1, 1'b1, 6'h08, 3'h0, 16'ha000, 3'h1, 1'b1, 3'h2);
    tag(3'h5, 1'b0, 4'h0, 1'b0, 3'h0, 2'h3, `NQC_ERR_PROFILE);
    tag(3'h5, 1'b1, 4'h9, 1'b0, 3'h0, 2'h0, `NQC_ERR_CLASS);
    pkt(1'b0, 1'b1, 1'b1, 6'h08, 3'h0, 16'ha000, 3'h1, 1'b1, 3'h2);
    tag(3'h7, 1'b1, 4'h0, 1'b0, 3'h0, 2'h0, `NQC_ERR_NONE);
    pkt(1'b0, 1'b1, 1'b1, 6'h08, 3'h0, 16'he000, 3'h0, 1'b0, 3'h2);
    tag(3'h0, 1'b1, 4'h4, 1'b1, 3'h1, 2'h1, `NQC_ERR_NONE);
    pkt(1'b0, 1'b1, 1'b1, 6'h08, 3'h0, 16'h1000, 3'h4, 1'b1, 3'h1);
    del(NQC_TBL_TAG, 6'h05);
    pkt(1'b0, 1'b1, 1'b1, 6'h08, 3'h0, 16'ha000, 3'h1, 1'b0, 3'h2);
    $display("test tag done");
    // A second reset in mid-run empties every table and restores the fallback
    i_rst = 1'b1;
    repeat (2) @(posedge i_core_clk);
    #1;
    chk(o_result, 8'h00, "result in second reset");
    i_rst = 1'b0;
    ippk(6'h08, 3'h0, 1'b1);
    pkt(1'b0, 1'b1, 1'b1, 6'h08, 3'h0, 16'he000, 3'h0, 1'b1, 3'h2);
    $display("test second reset done");
    test_done();
  end
endmodule

`default_nettype wire
